// ===== design/serial_in_parallel_out_latch8.sv
// Behaviour
// R1 - Eight shift stages load one bit at a time and are all visible.
// R2 - Each stage feeds one storage flop; only storage flops drive parallel outputs.
// R3 - Shift and storage banks clock independently; shifting leaves outputs alone.
// R4 - Each bank's clear overrides its clock and zeroes the whole bank.
// R5 - Last shift stage drives the cascade output directly, bypassing storage.
// R6 - Shift clear is active low; high lets shifting proceed.
// R7 - Shift stages change only on a rising shift clock edge.
// R8 - Storage bank changes only on a rising hold clock edge; here it loads on mclk, some cycles after the synchronised hold clock rise.
// R9 - Hold clear is active low and zeroes storage flops and outputs.
// R10 - Power-on reset leaves every register in a known state.
// R11 - Each shift edge loads serial input at stage 0, others move up.
// R12 - Each hold edge copies every shift stage into its storage flop; here an edge while one waits merges into it, copying only the newest word.
`timescale 1ns/10ps
`default_nettype none

module serial_in_parallel_out_latch8 (
  // System
  input  wire logic      mclk,
  input  wire logic      rst,
  // Shift side
  input  wire logic      shiftClock,
  input  wire logic      shiftClearN,
  input  wire logic      serialIn,
  // Transfer side
  input  wire logic      holdClock,
  input  wire logic      holdClearN,
  // Outputs
  output sipo_pkg::word_t parOut,
  output logic           cascadeOut
);

  import sipo_pkg::*;

  // ----------------------------------------------------------------
  // Shift bank, link clock domain
  // ----------------------------------------------------------------
  word_t stageQ;
  word_t stageD;

  always_comb begin
    stageD = {stageQ[STAGES-2:0], serialIn}; // R1 R11
  end

  // Clear is a direct asynchronous override, not sampled
  always_ff @(posedge shiftClock or posedge rst or negedge shiftClearN) begin // R7
    if (rst || !shiftClearN) begin
      stageQ <= STAGE_RST; // R4 R6 R10
    end else begin
      stageQ <= stageD;
    end
  end

  assign cascadeOut = stageQ[STAGES-1]; // R5

  // ----------------------------------------------------------------
  // Transfer pin synchronisers, mclk domain
  // ----------------------------------------------------------------
  function automatic logic settle(input logic s2, input logic s3, input logic prev);
    return (s2 == s3) ? s3 : prev;
  endfunction

  pinSample_t pinS1Q;
  pinSample_t pinS2Q;
  pinSample_t pinS3Q;
  pinSample_t pinS1D;
  logic       holdLvlQ;
  logic       holdLvlD;
  logic       clrLvlQ;
  logic       clrLvlD;
  logic       holdRise;

  always_comb begin
    pinS1D   = '{holdClk: holdClock, holdClrN: holdClearN};
    holdLvlD = settle(pinS2Q.holdClk, pinS3Q.holdClk, holdLvlQ);
    clrLvlD  = settle(pinS2Q.holdClrN, pinS3Q.holdClrN, clrLvlQ);
    holdRise = holdLvlD && !holdLvlQ; // R8
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinS1Q   <= PIN_RST;
      pinS2Q   <= PIN_RST;
      pinS3Q   <= PIN_RST;
      holdLvlQ <= 1'b0;
      clrLvlQ  <= 1'b0;
    end else begin
      pinS1Q   <= pinS1D;
      pinS2Q   <= pinS1Q;
      pinS3Q   <= pinS2Q;
      holdLvlQ <= holdLvlD;
      clrLvlQ  <= clrLvlD;
    end
  end

  // ----------------------------------------------------------------
  // Word crossing into mclk
  // ----------------------------------------------------------------
  // The shift bank is quiet around a transfer, so the word is taken
  // only once two later samples agree; a moving word is never latched.
  word_t wordAQ;
  word_t wordBQ;
  word_t wordCQ;
  logic  wordStable;
  logic  pendQ;
  logic  pendD;
  logic  bufInReady;
  logic  pushValid;
  logic  pushFire;
  xfer_t pushData;

  always_comb begin
    wordStable = (wordBQ == wordCQ);
    pushValid  = pendQ && wordStable && clrLvlQ;
    pushFire   = pushValid && bufInReady;
    pushData   = '{word: wordCQ}; // R12
    // A new edge while one waits merges into it: the newest word wins
    pendD      = ((holdRise && clrLvlQ) || (pendQ && !pushFire)) && clrLvlQ;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wordAQ <= STAGE_RST;
      wordBQ <= STAGE_RST;
      wordCQ <= STAGE_RST;
      pendQ  <= 1'b0; // R10
    end else begin
      wordAQ <= stageQ;
      wordBQ <= wordAQ;
      wordCQ <= wordBQ;
      pendQ  <= pendD;
    end
  end

  // ----------------------------------------------------------------
  // Transfer buffer
  // ----------------------------------------------------------------
  // A transfer during hold clear is dropped and the buffer flushed,
  // as a storage edge has no effect while the bank is held clear.
  logic  bufOutValid;
  logic  bufOutReady;
  xfer_t bufOutData;
  logic  loadFire;

  always_comb begin
    bufOutReady = clrLvlQ;
    loadFire    = bufOutValid && bufOutReady;
  end

  word_buffer2 #(
    .WIDTH ($bits(xfer_t)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk      (mclk),
    .rst      (rst),
    .flush    (!clrLvlQ),
    .inValid  (pushValid),
    .inReady  (bufInReady),
    .inData   (pushData),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // ----------------------------------------------------------------
  // Storage bank
  // ----------------------------------------------------------------
  word_t holdQ;
  word_t holdD;

  always_comb begin
    holdD = loadFire ? bufOutData.word : holdQ; // R3 R12
  end

  always_ff @(posedge mclk or posedge rst or negedge holdClearN) begin
    if (rst || !holdClearN) begin
      holdQ <= STAGE_RST; // R4 R9 R10
    end else begin
      holdQ <= holdD;
    end
  end

  assign parOut = holdQ; // R2

  // ----------------------------------------------------------------
  // Checks, link domain
  // ----------------------------------------------------------------
  logic [3:0] fillQ;
  logic [3:0] fillD;

  always_comb begin
    fillD = (fillQ == FILL_FULL) ? fillQ : fillQ + 4'h1;
  end

  always_ff @(posedge shiftClock or posedge rst or negedge shiftClearN) begin
    if (rst || !shiftClearN) begin
      fillQ <= FILL_RST;
    end else begin
      fillQ <= fillD;
    end
  end

  property p_shift_step;
    @(posedge shiftClock) disable iff (rst || !shiftClearN)
      (fillQ != FILL_RST) |->
        (stageQ[0] == $past(serialIn)) && (stageQ[STAGES-1:1] == $past(stageQ[STAGES-2:0]));
  endproperty
  a_shift_step: assert property (p_shift_step) // R11
    else $error("shift stages did not move by one");

  property p_cascade;
    @(posedge shiftClock) disable iff (rst || !shiftClearN)
      (fillQ == FILL_FULL) |-> (cascadeOut == $past(serialIn, 8));
  endproperty
  a_cascade: assert property (p_cascade) // R5
    else $error("cascade output is not the bit shifted in eight edges ago");

  property p_cascade_clear;
    @(posedge shiftClock) disable iff (rst)
      !shiftClearN |-> (stageQ == STAGE_RST) && !cascadeOut;
  endproperty
  a_cascade_clear: assert property (p_cascade_clear) // R4
    else $error("shift clock edge moved a cleared shift bank");

  // ----------------------------------------------------------------
  // Checks, mclk domain
  // ----------------------------------------------------------------
  property p_shift_clear;
    @(posedge mclk) disable iff (rst)
      (!shiftClearN && $past(!shiftClearN)) |-> (stageQ == STAGE_RST);
  endproperty
  a_shift_clear: assert property (p_shift_clear) // R6
    else $error("shift bank not zero under shift clear");

  property p_hold_clear;
    @(posedge mclk) disable iff (rst)
      (!holdClearN && $past(!holdClearN)) |-> (parOut == STAGE_RST);
  endproperty
  a_hold_clear: assert property (p_hold_clear) // R9
    else $error("parallel outputs not zero under hold clear");

  property p_quiet_outputs;
    @(posedge mclk) disable iff (rst)
      (holdClearN && $past(holdClearN) && !$past(loadFire)) |-> $stable(parOut);
  endproperty
  a_quiet_outputs: assert property (p_quiet_outputs) // R3
    else $error("parallel outputs moved without a transfer");

  sequence s_request;
    holdRise && clrLvlQ;
  endsequence

  sequence s_ready;
    clrLvlQ && wordStable && bufInReady;
  endsequence

  property p_request;
    @(posedge mclk) disable iff (rst)
      s_request ##1 s_ready |-> pushFire;
  endproperty
  a_request: assert property (p_request) // R8
    else $error("hold edge with a steady word was not pushed");

  property p_sync_rise;
    @(posedge mclk) disable iff (rst)
      holdRise |-> $past(holdClock, 2) && $past(holdClock, 3);
  endproperty
  a_sync_rise: assert property (p_sync_rise) // R8
    else $error("transfer edge seen without two high pin samples");

  sequence s_push_empty;
    pushFire && !bufOutValid && clrLvlQ;
  endsequence

  property p_push_shows;
    @(posedge mclk) disable iff (rst)
      s_push_empty ##1 clrLvlQ |->
        ##1 (!holdClearN || (parOut == $past(wordCQ, 2)));
  endproperty
  a_push_shows: assert property (p_push_shows) // R12
    else $error("captured word did not reach the outputs two cycles later");

  property p_load;
    @(posedge mclk) disable iff (rst)
      loadFire |=> (!holdClearN || (parOut == $past(bufOutData.word)));
  endproperty
  a_load: assert property (p_load) // R2
    else $error("storage bank did not take the buffered word");

  property p_drop_cleared;
    @(posedge mclk) disable iff (rst)
      !clrLvlQ |=> !pendQ && !bufOutValid;
  endproperty
  a_drop_cleared: assert property (p_drop_cleared) // R9
    else $error("transfer kept while hold clear was active");

  property p_reset;
    @(posedge mclk) disable iff (rst)
      $past(rst) |-> (parOut == STAGE_RST) && !pendQ && !bufOutValid;
  endproperty
  a_reset: assert property (p_reset) // R10
    else $error("state not defined after reset");

endmodule // serial_in_parallel_out_latch8

`default_nettype wire

// ===== design/sipo_pkg.sv
`default_nettype none

package sipo_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int STAGES     = 8;
  localparam int BUF_DEPTH  = 2;
  localparam int SYNC_DEPTH = 3;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 100;

  // ----------------------------------------------------------------
  // Reset values and fill limit
  // ----------------------------------------------------------------
  localparam logic [7:0] STAGE_RST = 8'h00;
  localparam logic [3:0] FILL_RST  = 4'h0;
  localparam logic [3:0] FILL_FULL = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [STAGES-1:0] word_t;

  // One transfer carried through the buffer
  typedef struct packed {
    word_t word;
  } xfer_t;

  // Transfer pins sampled together on mclk
  typedef struct packed {
    logic holdClk;
    logic holdClrN;
  } pinSample_t;

  localparam pinSample_t PIN_RST = '{holdClk: 1'b0, holdClrN: 1'b0};

endpackage

`default_nettype wire

// ===== design/word_buffer2.sv
`timescale 1ns/10ps
`default_nettype none

module word_buffer2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int            PW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int            CW   = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + 1'b1;
  endfunction

  logic [WIDTH-1:0] memQ   [DEPTH];
  logic [WIDTH-1:0] memD   [DEPTH];
  logic [PW-1:0]    wrPtrQ;
  logic [PW-1:0]    wrPtrD;
  logic [PW-1:0]    rdPtrQ;
  logic [PW-1:0]    rdPtrD;
  logic [CW-1:0]    countQ;
  logic [CW-1:0]    countD;
  logic             wrFire;
  logic             rdFire;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    inReady  = (countQ != FULL);
    outValid = (countQ != '0);
    outData  = memQ[rdPtrQ];
    wrFire   = inValid && inReady;
    rdFire   = outValid && outReady;
    memD     = memQ;
    wrPtrD   = wrPtrQ;
    rdPtrD   = rdPtrQ;
    countD   = countQ;
    if (wrFire) begin
      memD[wrPtrQ] = inData;
      wrPtrD       = bump(wrPtrQ);
    end
    if (rdFire) begin
      rdPtrD = bump(rdPtrQ);
    end
    case ({wrFire, rdFire})
      2'b10:   countD = countQ + 1'b1;
      2'b01:   countD = countQ - 1'b1;
      default: countD = countQ;
    endcase
    // Flush wins over a push in the same cycle
    if (flush) begin
      wrPtrD = '0;
      rdPtrD = '0;
      countD = '0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        memQ[i] <= '0;
      end
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else begin
      memQ   <= memD;
      wrPtrQ <= wrPtrD;
      rdPtrQ <= rdPtrD;
      countQ <= countD;
    end
  end

endmodule // word_buffer2

`default_nettype wire

// ===== testbench/host_link_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_link_model
  import sipo_pkg::*;
(
  // Command
  input  wire logic            sendReq,
  input  wire sipo_pkg::word_t sendWord,
  input  wire logic [3:0]      sendBits,
  output logic                 busy,
  // Link
  output logic                 shiftClock,
  output logic                 serialIn
);
  // ----------------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------------
  // Link clock stands low between frames; odd start offset keeps it off mclk phase
  initial begin
    busy       = 1'b0;
    shiftClock = 1'b0;
    serialIn   = 1'b0;
    forever begin
      wait (sendReq);
      busy = 1'b1;
      #7;
      for (int i = int'(sendBits) - 1; i >= 0; i--) begin
        serialIn = sendWord[i];
        #24 shiftClock = 1'b1;
        #24 shiftClock = 1'b0;
      end
      // Undriven line: never leave the last bit showing
      serialIn = ~serialIn;
      busy     = 1'b0;
      wait (!sendReq);
    end
  end
endmodule // host_link_model

`default_nettype wire

// ===== testbench/serial_in_parallel_out_latch8_tb.sv
`timescale 1ns/10ps
`default_nettype none

module serial_in_parallel_out_latch8_tb;
  import sipo_pkg::*;

  logic       mclk, rst, shiftClearN, holdClock, holdClearN;
  logic       sendReq, busy, shiftClock, serialIn, cascadeOut;
  logic [3:0] sendBits;
  word_t      parOut, sendWord, expShift, expOut, w;
  int         err_total, cmp_count, cycles;

  serial_in_parallel_out_latch8 serial_in_parallel_out_latch8_i (
    .mclk(mclk), .rst(rst), .shiftClock(shiftClock), .shiftClearN(shiftClearN),
    .serialIn(serialIn), .holdClock(holdClock), .holdClearN(holdClearN),
    .parOut(parOut), .cascadeOut(cascadeOut));

  host_link_model host_link_model_i (
    .sendReq(sendReq), .sendWord(sendWord), .sendBits(sendBits), .busy(busy),
    .shiftClock(shiftClock), .serialIn(serialIn));

  // ----------------------------------------------------------------
  // Clock, timeout, verdict
  // ----------------------------------------------------------------
  initial mclk = 1'b0;
  always #(MCLK_PERIOD_NS / 2) mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out;
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic word_t exp_shift(input word_t old, input word_t d, input logic [3:0] n);
    return (old << n) | (d & ((8'h01 << n) - 8'h01));
  endfunction

  task automatic check_word(input string what, input word_t exp, input word_t got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Shift n bits of d, then confirm cascade and untouched outputs
  task automatic send(input word_t d, input logic [3:0] n);
    int k;
    k = 0;
    sendWord <= d;
    sendBits <= n;
    sendReq  <= 1'b1;
    while (busy !== 1'b1 && k < 50) begin
      @(posedge mclk);
      k++;
    end
    sendReq <= 1'b0;
    while (busy !== 1'b0 && k < 100) begin
      @(posedge mclk);
      k++;
    end
    if (shiftClearN)
      expShift = exp_shift(expShift, d, n);
    @(negedge mclk);
    check_bit("cascadeOut", expShift[7], cascadeOut);
    check_word("parOut held", expOut, parOut);
    @(posedge mclk);
  endtask

  // Hold clock pulse; link stays quiet before and after
  task automatic transfer;
    wait_cycles(5);
    holdClock <= 1'b1;
    wait_cycles(4);
    holdClock <= 1'b0;
    wait_cycles(6);
    if (holdClearN)
      expOut = expShift;
    @(negedge mclk);
    check_word("parOut load", expOut, parOut);
    @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst         = 1'b1;
    shiftClearN = 1'b1;
    holdClock   = 1'b0;
    holdClearN  = 1'b1;
    sendReq     = 1'b0;
    sendWord    = 8'h00;
    sendBits    = 4'h8;
    expShift    = 8'h00;
    expOut      = 8'h00;
    err_total   = 0;
    cmp_count   = 0;
    cycles      = 0;
    void'($urandom(32'hbd59));
    wait_cycles(4);
    rst <= 1'b0;
    wait_cycles(6);
    @(negedge mclk);
    check_word("parOut reset", 8'h00, parOut);
    check_bit("cascadeOut reset", 1'b0, cascadeOut);
    @(posedge mclk);
    // Corners first, then random words of random length
    for (int t = 0; t < 14; t++) begin
      w = (t == 0) ? 8'hff : (t == 1) ? 8'h01 : (t == 2) ? 8'ha5 : word_t'($urandom);
      send(w, (t < 3) ? 4'h8 : 4'($urandom_range(8, 1)));
      if (t != 1)
        transfer();
    end
    // Shift clear overrides link edges
    send(8'h81, 4'h8);
    shiftClearN <= 1'b0;
    expShift = 8'h00;
    @(negedge mclk);
    check_bit("cascadeOut clear", 1'b0, cascadeOut);
    check_word("parOut on shift clear", expOut, parOut);
    @(posedge mclk);
    send(8'hff, 4'h8);
    shiftClearN <= 1'b1;
    transfer();
    // Hold clear zeroes outputs and drops transfers
    send(8'h3c, 4'h8);
    transfer();
    holdClearN <= 1'b0;
    expOut = 8'h00;
    @(negedge mclk);
    check_word("parOut hold clear", 8'h00, parOut);
    @(posedge mclk);
    transfer();
    holdClearN <= 1'b1;
    wait_cycles(8);
    @(negedge mclk);
    check_word("parOut dropped", 8'h00, parOut);
    @(posedge mclk);
    transfer();
    close_out();
  end
endmodule // serial_in_parallel_out_latch8_tb

`default_nettype wire
